// *** sim/umsf_modem_flow_tb_top.sv ***
`timescale 1ns/100ps

module umsf_modem_flow_tb_top;
  import umsf_pkg::*;
  logic           ref_clk = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic           enhancedEnable = 1'b0, specialSelect = 1'b0, modemIntEnable = 1'b0;
  logic           autoRtsEnable = 1'b0, autoSoftFlowEnable = 1'b0;
  logic [3:0]     regAddr = 4'h0, lineReq = 4'hF;
  umsf_byte_type  regWrData = 8'h00, lineControl = 8'h00, modemControl = 8'h00;
  umsf_byte_type  fifoControl = 8'h00, specialUnlock = 8'h00;
  umsf_count_type rxFifoCount = 7'h00, txFifoSpace = 7'h00;
  logic           ctsN, dsrN, riN, cdN, rtsN, sendXon, sendXoff;
  logic           rxTrigger, txTrigger, modemIrq;
  umsf_byte_type  regRdData, xoffCharFirst, xoffCharSecond, rdv;
  int             errorCnt = 0, testsRun = 0;
  // Levels of the FIFO control field, the design's parameter defaults
  umsf_count_type lv [4] = '{7'h08, 7'h10, 7'h20, 7'h30};

  umsf_modem_flow dut_u (
    .ref_clk, .rst, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData,
    .lineControl, .modemControl, .fifoControl, .specialUnlock, .enhancedEnable,
    .specialSelect, .modemIntEnable, .autoRtsEnable, .autoSoftFlowEnable,
    .rxFifoCount, .txFifoSpace, .ctsN, .dsrN, .riN, .cdN, .rtsN, .sendXon,
    .sendXoff, .rxTrigger, .txTrigger, .modemIrq, .xoffCharFirst, .xoffCharSecond
  );
  umsf_modem_peer peer_u (.ref_clk, .lineReq, .ctsN, .dsrN, .riN, .cdN);

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : settle
  task automatic wr(input logic [3:0] a, input umsf_byte_type d);
    @(negedge ref_clk);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    @(negedge ref_clk);
    regWrEn = 1'b0;
  endtask : wr
  // Read data is registered, so it is taken one falling edge after the read edge
  task automatic rd(input logic [3:0] a);
    @(negedge ref_clk);
    {regAddr, regRdEn} = {a, 1'b1};
    @(negedge ref_clk);
    regRdEn = 1'b0;
    rdv = regRdData;
  endtask : rd
  task automatic rdChk(input logic [3:0] a, input umsf_byte_type exp, input string what);
    rd(a);
    check(what, rdv, exp);
  endtask : rdChk
  task automatic sel(input umsf_byte_type lineCtl, input umsf_byte_type modemCtl,
                     input logic enh, input logic ss);
    @(negedge ref_clk);
    {lineControl, modemControl, enhancedEnable, specialSelect} = {lineCtl, modemCtl, enh, ss};
  endtask : sel
  task automatic finishTest;
    if (errorCnt == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finishTest

  task automatic regAccess;
    rdChk(4'h6, 8'h00, "status reset");
    rdChk(4'h7, 8'hFF, "scratch reset");
    rdChk(4'h3, 8'h00, "unmapped");
    wr(4'h7, 8'hA5);
    rdChk(4'h7, 8'hA5, "scratch");
    sel(8'h00, 8'h04, 1'b1, 1'b0);
    rdChk(4'h6, 8'h00, "thresh reset");
    rdChk(4'h7, 8'h00, "trigger reset");
    // Resume 8 and halt 16 stay around rx trigger 12
    wr(4'h6, 8'h24);
    wr(4'h7, 8'h32);
    rdChk(4'h6, 8'h24, "thresh");
    rdChk(4'h7, 8'h32, "trigger");
    sel(8'h00, 8'h04, 1'b0, 1'b1);
    rdChk(4'h6, 8'h00, "thresh hidden");
    sel(8'hBF, 8'h00, 1'b0, 1'b0);
    rdChk(4'h7, 8'h00, "xoff second reset");
    wr(4'h6, 8'h13);
    wr(4'h7, 8'h17);
    rdChk(4'h6, 8'h13, "xoff first");
    check("xoff first out", xoffCharFirst, 8'h13);
    check("xoff second out", xoffCharSecond, 8'h17);
    sel(8'hBF, 8'h00, 1'b0, 1'b1);
    wr(4'h6, 8'h55);
    rdChk(4'h6, 8'h00, "xoff first hidden");
    check("xoff first kept", xoffCharFirst, 8'h13);
    specialUnlock = 8'h5A;
    wr(4'h7, 8'h99);
    rdChk(4'h7, 8'h00, "xoff second hidden");
    check("xoff second kept", xoffCharSecond, 8'h17);
    specialUnlock = 8'h00;
  endtask : regAccess

  task automatic modemPins;
    sel(8'h00, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      modemIntEnable = (i != 0);
      lineReq[i] = 1'b0;
      settle(5);
      check("irq fall", {7'h00, modemIrq}, {7'h00, i != 0 && i != 2});
      rdChk(4'h6, (8'h10 << i) | (i == 2 ? 8'h00 : 8'h01 << i), "fall");
      rdChk(4'h6, 8'h10 << i, "flags cleared");
      check("irq cleared", {7'h00, modemIrq}, 8'h00);
      lineReq[i] = 1'b1;
      settle(5);
      check("irq rise", {7'h00, modemIrq}, {7'h00, i != 0});
      rdChk(4'h6, 8'h01 << i, "rise");
    end
  endtask : modemPins

  task automatic loopBack;
    umsf_byte_type ctlT [4] = '{8'h11, 8'h12, 8'h14, 8'h18};
    umsf_byte_type expT [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
    sel(8'h00, 8'h1F, 1'b1, 1'b0);
    settle(5);
    rd(4'h6);
    rdChk(4'h6, 8'hF0, "loop all");
    lineReq = 4'h0;
    for (int k = 0; k < 4; k++) begin
      modemControl = ctlT[k];
      settle(5);
      rd(4'h6);
      check("loop bit", rdv & 8'hF0, expT[k]);
    end
    lineReq = 4'hF;
  endtask : loopBack

  task automatic flowCtl;
    sel(8'h00, 8'h00, 1'b0, 1'b0);
    {autoRtsEnable, autoSoftFlowEnable} = 2'b11;
    rxFifoCount = 7'd15;
    settle(3);
    check("no early xoff", {7'h00, sendXoff}, 8'h00);
    rxFifoCount = 7'd16;
    settle(1);
    check("halt", {6'h00, rtsN, sendXoff}, 8'h03);
    rxFifoCount = 7'd9;
    for (int k = 0; k < 3; k++) begin
      settle(1);
      check("held", {6'h00, rtsN, sendXoff | sendXon}, 8'h02);
    end
    rxFifoCount = 7'd8;
    settle(1);
    check("resume", {6'h00, rtsN, sendXon}, 8'h01);
    settle(1);
    check("xon once", {7'h00, sendXon}, 8'h00);
    {autoRtsEnable, autoSoftFlowEnable} = 2'b00;
  endtask : flowCtl

  task automatic triggers;
    {rxFifoCount, txFifoSpace} = {7'd11, 7'd7};
    settle(2);
    check("trig below", {6'h00, rxTrigger, txTrigger}, 8'h00);
    {rxFifoCount, txFifoSpace} = {7'd12, 7'd8};
    settle(2);
    check("trig at", {6'h00, rxTrigger, txTrigger}, 8'h03);
    sel(8'h00, 8'h04, 1'b1, 1'b0);
    wr(4'h7, 8'h00);
    for (int k = 0; k < 4; k++) begin
      fifoControl = {k[1:0], k[1:0], 4'h0};
      {rxFifoCount, txFifoSpace} = {lv[k] - 7'd1, lv[k] - 7'd1};
      settle(2);
      check("fcr below", {6'h00, rxTrigger, txTrigger}, 8'h00);
      {rxFifoCount, txFifoSpace} = {lv[k], lv[k]};
      settle(2);
      check("fcr at", {6'h00, rxTrigger, txTrigger}, 8'h03);
    end
  endtask : triggers

  always #2 ref_clk = ~ref_clk;
  initial begin
    settle(8);
    rst = 1'b0;
    regAccess();
    modemPins();
    loopBack();
    flowCtl();
    triggers();
    finishTest();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    errorCnt++;
    finishTest();
  end
endmodule : umsf_modem_flow_tb_top

// *** sim/umsf_modem_peer.sv ***
`timescale 1ns/100ps

module umsf_modem_peer (
  // Clock and requested levels, {cd, ri, dsr, cts}
  input  wire logic       ref_clk,
  input  wire logic [3:0] lineReq,
  // Modem lines, active low
  output logic            ctsN,
  output logic            dsrN,
  output logic            riN,
  output logic            cdN
);
  // Idle high; lines move after a falling edge, never with the sampling edge
  initial begin
    {cdN, riN, dsrN, ctsN} = 4'hF;
    forever @(negedge ref_clk) {cdN, riN, dsrN, ctsN} <= lineReq;
  end
endmodule : umsf_modem_peer

// *** verilog/umsf_modem_flow.sv ***
`timescale 1ns/100ps
`include "umsf_regs.svh"

module umsf_modem_flow #(
  parameter logic [6:0] RX_LEVEL_0 = 7'h08,
  parameter logic [6:0] RX_LEVEL_1 = 7'h10,
  parameter logic [6:0] RX_LEVEL_2 = 7'h20,
  parameter logic [6:0] RX_LEVEL_3 = 7'h30,
  parameter logic [6:0] TX_LEVEL_0 = 7'h08,
  parameter logic [6:0] TX_LEVEL_1 = 7'h10,
  parameter logic [6:0] TX_LEVEL_2 = 7'h20,
  parameter logic [6:0] TX_LEVEL_3 = 7'h30
) (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // Host register port
  input  wire logic [`UMSF_ADDR_W-1:0]  regAddr,
  input  wire logic                     regWrEn,
  input  wire logic                     regRdEn,
  input  wire umsf_pkg::umsf_byte_type  regWrData,
  output umsf_pkg::umsf_byte_type       regRdData,
  // Neighbouring register contents
  input  wire umsf_pkg::umsf_byte_type  lineControl,
  input  wire umsf_pkg::umsf_byte_type  modemControl,
  input  wire umsf_pkg::umsf_byte_type  fifoControl,
  input  wire umsf_pkg::umsf_byte_type  specialUnlock,
  input  wire logic                     enhancedEnable,
  input  wire logic                     specialSelect,
  input  wire logic                     modemIntEnable,
  // Flow control enables
  input  wire logic                     autoRtsEnable,
  input  wire logic                     autoSoftFlowEnable,
  // FIFO levels
  input  wire umsf_pkg::umsf_count_type rxFifoCount,
  input  wire umsf_pkg::umsf_count_type txFifoSpace,
  // Modem pins, active low
  input  wire logic                     ctsN,
  input  wire logic                     dsrN,
  input  wire logic                     riN,
  input  wire logic                     cdN,
  output logic                          rtsN,
  // Flow and trigger events
  output logic                          sendXon,
  output logic                          sendXoff,
  output logic                          rxTrigger,
  output logic                          txTrigger,
  output logic                          modemIrq,
  // Characters for the transmitter
  output umsf_pkg::umsf_byte_type       xoffCharFirst,
  output umsf_pkg::umsf_byte_type       xoffCharSecond
);
  import umsf_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic umsf_count_type umsf_times4(input logic [3:0] nib);
    umsf_times4 = {1'b0, nib, 2'b00};
  endfunction : umsf_times4

  function automatic umsf_count_type umsf_pick(input logic [1:0] sel,
                                               input umsf_count_type l0,
                                               input umsf_count_type l1,
                                               input umsf_count_type l2,
                                               input umsf_count_type l3);
    case (sel)
      2'b00:   umsf_pick = l0;
      2'b01:   umsf_pick = l1;
      2'b10:   umsf_pick = l2;
      default: umsf_pick = l3;
    endcase
  endfunction : umsf_pick

  umsf_state_type        state_q;
  umsf_state_type        state_d;
  logic [`UMSF_PINS-1:0] pinSync;
  logic [3:0]            status;
  logic [3:0]            deltaSet;
  logic                  loopback;
  logic                  lineKey;
  logic                  altSelect;
  logic                  selXoffFirst;
  logic                  selThresh;
  logic                  selStatus;
  logic                  selXoffSecond;
  logic                  selTrigger;
  logic                  selScratch;
  logic                  hitStatus;
  logic                  hitScratch;
  umsf_byte_type         statusByte;
  umsf_count_type        resumeLevel;
  umsf_count_type        haltLevel;
  umsf_count_type        rxLevel;
  umsf_count_type        txLevel;
  logic                  flowOn;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  umsf_pin_sync u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .pinAsync ({cdN, riN, dsrN, ctsN}),
    .pinSync  (pinSync)
  );

  // ----------------------------------------------------------------
  // Modem status view
  // ----------------------------------------------------------------
  assign loopback = modemControl[`UMSF_MODEM_LOOP];

  // Order {CD, RI, DSR, CTS}
  always_comb begin
    if (loopback) begin
      status = {modemControl[`UMSF_MODEM_OUT2],
                modemControl[`UMSF_MODEM_OUT1],
                modemControl[`UMSF_MODEM_DTR],
                modemControl[`UMSF_MODEM_RTS]};
    end else begin
      status = ~{pinSync[`UMSF_PIN_CD], pinSync[`UMSF_PIN_RI],
                 pinSync[`UMSF_PIN_DSR], pinSync[`UMSF_PIN_CTS]};
    end
  end

  // RI flags only the pin's rise, i.e. status bit falling
  assign deltaSet = {status[3] ^ state_q.prevStatus[3],
                     state_q.prevStatus[2] & ~status[2],
                     status[1] ^ state_q.prevStatus[1],
                     status[0] ^ state_q.prevStatus[0]};

  assign statusByte = {status, state_q.delta};

  // ----------------------------------------------------------------
  // Register select
  // ----------------------------------------------------------------
  assign lineKey   = (lineControl == `UMSF_LINE_KEY);
  // Loopback reuses control bit 2 as a status source, so it stops selecting
  assign altSelect = modemControl[`UMSF_MODEM_OUT1] & ~loopback;

  assign selXoffFirst  = lineKey & ~specialSelect;
  assign selThresh     = ~selXoffFirst & enhancedEnable & altSelect & ~specialSelect;
  assign selStatus     = ~selXoffFirst & ~lineControl[`UMSF_LINE_DIV] & ~altSelect
                         & ~specialSelect;
  assign selXoffSecond = lineKey & (specialUnlock != `UMSF_UNLOCK_KEY);
  assign selTrigger    = ~selXoffSecond & enhancedEnable & altSelect;
  assign selScratch    = ~selXoffSecond & ~lineControl[`UMSF_LINE_DIV] & ~altSelect;

  assign hitStatus  = (regAddr == `UMSF_OFS_STATUS_THR);
  assign hitScratch = (regAddr == `UMSF_OFS_SCRATCH_TRIG);

  // ----------------------------------------------------------------
  // Thresholds and trigger levels
  // ----------------------------------------------------------------
  assign resumeLevel = umsf_times4(state_q.thresh[7:4]);
  assign haltLevel   = umsf_times4(state_q.thresh[3:0]);
  assign rxLevel     = (state_q.trigger[7:4] != 4'h0) ? umsf_times4(state_q.trigger[7:4]) :
                       umsf_pick(fifoControl[`UMSF_FIFO_RXT_HI:`UMSF_FIFO_RXT_LO],
                                 RX_LEVEL_0, RX_LEVEL_1, RX_LEVEL_2, RX_LEVEL_3);
  assign txLevel     = (state_q.trigger[3:0] != 4'h0) ? umsf_times4(state_q.trigger[3:0]) :
                       umsf_pick(fifoControl[`UMSF_FIFO_TXT_HI:`UMSF_FIFO_TXT_LO],
                                 TX_LEVEL_0, TX_LEVEL_1, TX_LEVEL_2, TX_LEVEL_3);
  // Zero halt nibble disables automatic flow, avoiding a halt at empty
  assign flowOn      = (autoRtsEnable | autoSoftFlowEnable) & (state_q.thresh[3:0] != 4'h0);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d            = state_q;
    state_d.prevStatus = status;
    state_d.sendXon    = 1'b0;
    state_d.sendXoff   = 1'b0;

    // Set wins over the clear from a status read
    if (regRdEn && hitStatus && selStatus) begin
      state_d.delta = deltaSet;
    end else begin
      state_d.delta = state_q.delta | deltaSet;
    end

    if (regWrEn && hitStatus) begin
      if (selXoffFirst) begin
        state_d.xoffFirst = regWrData;
      end else if (selThresh) begin
        state_d.thresh = regWrData;
      end
    end
    if (regWrEn && hitScratch) begin
      if (selXoffSecond) begin
        state_d.xoffSecond = regWrData;
      end else if (selTrigger) begin
        state_d.trigger = regWrData;
      end else if (selScratch) begin
        state_d.scratch = regWrData;
      end
    end

    if (!flowOn) begin
      state_d.halted = 1'b0;
    end else if (!state_q.halted && rxFifoCount >= haltLevel) begin
      state_d.halted   = 1'b1;
      state_d.sendXoff = autoSoftFlowEnable;
    end else if (state_q.halted && rxFifoCount <= resumeLevel) begin
      state_d.halted  = 1'b0;
      state_d.sendXon = autoSoftFlowEnable;
    end

    // With auto RTS off, control bit 1 set drives the pin low; with it on, the pin is high while halted
    state_d.rtsN      = autoRtsEnable ? state_d.halted : ~modemControl[`UMSF_MODEM_RTS];
    state_d.rxTrigger = (rxFifoCount >= rxLevel);
    state_d.txTrigger = (txFifoSpace >= txLevel);
    state_d.modemIrq  = modemIntEnable & (|state_d.delta);

    if (regRdEn) begin
      if (hitStatus && selXoffFirst) begin
        state_d.rdData = state_q.xoffFirst;
      end else if (hitStatus && selThresh) begin
        state_d.rdData = state_q.thresh;
      end else if (hitStatus && selStatus) begin
        state_d.rdData = statusByte;
      end else if (hitScratch && selXoffSecond) begin
        state_d.rdData = state_q.xoffSecond;
      end else if (hitScratch && selTrigger) begin
        state_d.rdData = state_q.trigger;
      end else if (hitScratch && selScratch) begin
        state_d.rdData = state_q.scratch;
      end else begin
        state_d.rdData = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q            <= '0;
      state_q.scratch    <= `UMSF_RST_SCRATCH;
      state_q.thresh     <= `UMSF_RST_THRESH;
      state_q.trigger    <= `UMSF_RST_TRIGGER;
      state_q.xoffFirst  <= `UMSF_RST_XOFF;
      state_q.xoffSecond <= `UMSF_RST_XOFF;
      state_q.rtsN       <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign regRdData      = state_q.rdData;
  assign rtsN           = state_q.rtsN;
  assign sendXon        = state_q.sendXon;
  assign sendXoff       = state_q.sendXoff;
  assign rxTrigger      = state_q.rxTrigger;
  assign txTrigger      = state_q.txTrigger;
  assign modemIrq       = state_q.modemIrq;
  assign xoffCharFirst  = state_q.xoffFirst;
  assign xoffCharSecond = state_q.xoffSecond;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOOP_STATUS: assert property (@(posedge ref_clk) disable iff (rst)
    (regRdEn && hitStatus && selStatus && loopback)
    |=> regRdData[7:4] == {$past(modemControl[3]), $past(modemControl[2]),
                           $past(modemControl[0]), $past(modemControl[1])})
    else $error("loopback status bits wrong");

  AST_CTS_DELTA: assert property (@(posedge ref_clk) disable iff (rst)
    (!loopback && $changed(pinSync[`UMSF_PIN_CTS]) && !$past(loopback))
    |-> ##1 state_q.delta[0])
    else $error("cts change not flagged");

  AST_RI_EDGE: assert property (@(posedge ref_clk) disable iff (rst)
    (!loopback && !$past(loopback) && $fell(pinSync[`UMSF_PIN_RI]))
    |=> state_q.delta[2] == $past(state_q.delta[2] && !(regRdEn && hitStatus && selStatus)))
    else $error("ri falling pin flagged");

  AST_READ_CLEAR: assert property (@(posedge ref_clk) disable iff (rst)
    (regRdEn && hitStatus && selStatus && deltaSet == 4'h0) |=> state_q.delta == 4'h0)
    else $error("status read did not clear flags");

  AST_MODEM_IRQ: assert property (@(posedge ref_clk) disable iff (rst)
    (modemIntEnable && deltaSet != 4'h0) |=> modemIrq)
    else $error("modem interrupt missing");

  AST_HALT: assert property (@(posedge ref_clk) disable iff (rst)
    (flowOn && autoRtsEnable && !state_q.halted && rxFifoCount >= haltLevel)
    |=> rtsN && $past(autoSoftFlowEnable) == sendXoff)
    else $error("halt threshold not acted on");

  AST_RESUME: assert property (@(posedge ref_clk) disable iff (rst)
    (flowOn && state_q.halted && rxFifoCount <= resumeLevel) |=> !state_q.halted)
    else $error("resume threshold not acted on");

  AST_RX_TRIG: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q.trigger[7:4] != 4'h0)
    |=> rxTrigger == ($past(rxFifoCount) >= {1'b0, $past(state_q.trigger[7:4]), 2'b00}))
    else $error("receive trigger wrong");

  AST_TX_TRIG: assert property (@(posedge ref_clk) disable iff (rst)
    (state_q.trigger[3:0] != 4'h0)
    |=> txTrigger == ($past(txFifoSpace) >= {1'b0, $past(state_q.trigger[3:0]), 2'b00}))
    else $error("transmit trigger wrong");

  AST_XOFF_FIRST_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    (regWrEn && hitStatus && lineKey && !specialSelect)
    |=> xoffCharFirst == $past(regWrData) && state_q.thresh == $past(state_q.thresh))
    else $error("first xoff write wrong");

  AST_SCRATCH_WRITE: assert property (@(posedge ref_clk) disable iff (rst)
    (regWrEn && hitScratch && !lineControl[`UMSF_LINE_DIV]
     && !(modemControl[`UMSF_MODEM_OUT1] && !loopback))
    |=> state_q.scratch == $past(regWrData))
    else $error("scratch write lost");

  AST_XOFF_SECOND_HIDE: assert property (@(posedge ref_clk) disable iff (rst)
    (regWrEn && hitScratch && specialUnlock == `UMSF_UNLOCK_KEY)
    |=> xoffCharSecond == $past(xoffCharSecond))
    else $error("hidden second xoff written");

endmodule : umsf_modem_flow

// *** verilog/umsf_pin_sync.sv ***
`timescale 1ns/100ps
`include "umsf_regs.svh"

module umsf_pin_sync (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Pins
  input  wire logic [`UMSF_PINS-1:0] pinAsync,
  output logic      [`UMSF_PINS-1:0] pinSync
);
  import umsf_pkg::*;

  umsf_sync_type syncState_q;
  umsf_sync_type syncState_d;

  always_comb begin
    syncState_d        = syncState_q;
    syncState_d.meta   = pinAsync;
    syncState_d.stable = syncState_q.meta;
  end

  // Idle high so no false change flags right after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncState_q <= {`UMSF_PIN_IDLE, `UMSF_PIN_IDLE};
    end else begin
      syncState_q <= syncState_d;
    end
  end

  assign pinSync = syncState_q.stable;

endmodule : umsf_pin_sync

// *** verilog/umsf_pkg.sv ***
`include "umsf_regs.svh"

package umsf_pkg;

  typedef logic [7:0] umsf_byte_type;
  typedef logic [6:0] umsf_count_type;

  typedef struct packed {
    logic [`UMSF_PINS-1:0] meta;
    logic [`UMSF_PINS-1:0] stable;
  } umsf_sync_type;

  typedef struct packed {
    umsf_byte_type         scratch;
    umsf_byte_type         thresh;
    umsf_byte_type         trigger;
    umsf_byte_type         xoffFirst;
    umsf_byte_type         xoffSecond;
    logic [3:0]            delta;
    logic [3:0]            prevStatus;
    logic                  halted;
    logic                  rtsN;
    logic                  sendXon;
    logic                  sendXoff;
    logic                  rxTrigger;
    logic                  txTrigger;
    logic                  modemIrq;
    umsf_byte_type         rdData;
  } umsf_state_type;

endpackage : umsf_pkg

// *** verilog/umsf_regs.svh ***
`ifndef UMSF_REGS_SVH
`define UMSF_REGS_SVH

// ----------------------------------------------------------------
// Register locations
// ----------------------------------------------------------------
`define UMSF_ADDR_W          4
`define UMSF_OFS_STATUS_THR  4'h6
`define UMSF_OFS_SCRATCH_TRIG 4'h7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UMSF_RST_SCRATCH     8'hFF
`define UMSF_RST_THRESH      8'h00
`define UMSF_RST_TRIGGER     8'h00
`define UMSF_RST_XOFF        8'h00

// ----------------------------------------------------------------
// Unlock keys and control bit positions
// ----------------------------------------------------------------
`define UMSF_LINE_KEY        8'hBF
`define UMSF_UNLOCK_KEY      8'h5A
`define UMSF_LINE_DIV        7
`define UMSF_MODEM_DTR       0
`define UMSF_MODEM_RTS       1
`define UMSF_MODEM_OUT1      2
`define UMSF_MODEM_OUT2      3
`define UMSF_MODEM_LOOP      4
`define UMSF_FIFO_RXT_HI     7
`define UMSF_FIFO_RXT_LO     6
`define UMSF_FIFO_TXT_HI     5
`define UMSF_FIFO_TXT_LO     4

// ----------------------------------------------------------------
// Modem pin order and synchroniser idle level
// ----------------------------------------------------------------
`define UMSF_PIN_CTS         0
`define UMSF_PIN_DSR         1
`define UMSF_PIN_RI          2
`define UMSF_PIN_CD          3
`define UMSF_PINS            4
`define UMSF_PIN_IDLE        4'hF

`endif
